//--- hdl/pmw_cfg.svh
`ifndef PMW_CFG_SVH
`define PMW_CFG_SVH
// register byte offsets
`define PMW_OFS_MODE    8'h00
`define PMW_OFS_CTRL    8'h04
`define PMW_OFS_STAT    8'h08
`define PMW_OFS_WAKE    8'h0c
// reset values
`define PMW_MODE_RST    8'h03
`define PMW_CTRL_RST    8'h00
`define PMW_WAKE_RST    8'h00
// field positions
`define PMW_MODE_DIV    5
`define PMW_MODE_SRDY   3
`define PMW_MODE_FRDY   2
`define PMW_MODE_IDLE   1
`define PMW_MODE_FAST   0
`define PMW_CTRL_SYSON  7
`define PMW_STAT_PDF    0
`define PMW_STAT_TO     1
// divider codes at or below this pick the sub clock
`define PMW_DIV_SUB_MAX 3'h1
// oscillator settle counts in cycles
`define PMW_LXT_CYC     11'd1024
`define PMW_INT_SLOW_OSC_CYC    11'd2
`define PMW_HTO_CYC     5'd16
`endif

//--- hdl/pmw_pkg.sv
package pmw_pkg;

  typedef enum logic [5:0] {
    PMW_RUN   = 6'h01,
    PMW_DEEP  = 6'h02,
    PMW_SLSUB = 6'h04,
    PMW_IDL0  = 6'h08,
    PMW_IDL1  = 6'h10,
    PMW_WAKE  = 6'h20
  } pmw_state_t;

  typedef struct packed {
    logic cpu;
    logic sys;
    logic wdt;
    logic tbc;
    logic sub;
    logic fast_osc;
    logic div16;
    logic div64;
  } pmw_gate_t;

  typedef struct packed {
    logic wdt;
    logic irq;
    logic porta;
  } pmw_wake_t;

endpackage

//--- hdl/pmw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmw_cfg.svh"
// How it works
// - halt picks idle or sleep, idle flavour
// - fast bit clear, code 000/001 runs sub
// - fast oscillator stops while on sub clock
// - divided fast clocks stop with oscillator
// - switch to sub waits for slow ready
// - fast bit or codes 010-111 use fast
// - idle off, wdt and lvd off: deep sleep
// - deep sleep clears and stops watchdog
// - idle off, wdt or lvd on: sleep_with_subclock_state
// - other low states clear, keep watchdog counting
// - idle on, sysclk bit off: idle_sysclk_off_state
// - idle on, sysclk bit on: idle_sysclk_on_state
// - low states freeze cpu, keep contents
// - entry sets power-down, clears time-out
// - wake on port A, interrupt, watchdog
// - watchdog wake sets time-out, resets pc/sp
// - power-down cleared by reset, clear-wdt
// - per-pin port A wake enable, resume
// - masked or stack-full irq resumes after halt
// - enabled irq with stack room is serviced
// - flags already set never wake
// - divider codes pick sub or fast/64../2
// - slow ready after 1024 or 2 cycles
// - fast ready 16 cycles after restart
// - lvd enabled blocks deep sleep
module pmw_ctrl
  import pmw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  input  wire logic       halt_exec,
  input  wire logic       clr_wdt_exec,
  input  wire logic       wdt_enable,
  input  wire logic       voltage_detect_enable,
  input  wire logic       wdt_overflow,
  input  wire logic       ext_slow_crystal_sel,
  input  wire logic       slow_osc_clk,
  input  wire logic [7:0] porta_pins,
  input  wire logic [7:0] irq_req,
  input  wire logic [7:0] irq_enable,
  input  wire logic       stack_full,
  output pmw_gate_t       clk_gate,
  output logic            sys_tick,
  output logic            using_sub_clk,
  output pmw_state_t      power_state,
  output logic            wdt_clear,
  output logic            wdt_run,
  output logic            power_down_flag,
  output logic            watchdog_timeout_flag,
  output pmw_wake_t       wake_source,
  output logic            resume_next,
  output logic            irq_service,
  output logic            pc_sp_reset
);

  pmw_state_t state_r;
  pmw_state_t state_nxt;
  logic [2:0] clock_divider_select_r;
  logic       idle_on_halt_enable_r;
  logic       fast_clock_select_r;
  logic       sysclk_in_idle_enable_r;
  logic [7:0] porta_wake_enable_r;
  logic       using_sub_r;
  logic       pdf_r;
  logic       to_r;
  logic [7:0] irq_snap_r;
  pmw_wake_t  wake_src_r;
  logic       resume_r;
  logic       irq_svc_r;
  logic       pcsp_r;
  logic       wdt_clr_r;
  logic       tick_r;
  logic [7:0] rdata_r;
  logic [10:0] slow_cnt_r;
  logic       slow_rdy_r;
  logic [4:0] fast_cnt_r;
  logic       fast_rdy_r;
  logic [5:0] presc_r;
  logic [7:0] pa_s1_r;
  logic [7:0] pa_s2_r;
  logic [7:0] pa_s3_r;
  logic       sc_s1_r;
  logic       sc_s2_r;
  logic       sc_s3_r;

  // state decode
  wire st_run  = state_r == PMW_RUN;
  wire st_deep = state_r == PMW_DEEP;
  wire st_idl0 = state_r == PMW_IDL0;
  wire st_idl1 = state_r == PMW_IDL1;
  wire st_wake = state_r == PMW_WAKE;
  wire st_low  = ~st_run & ~st_wake;

  // register decode
  wire sel_mode = reg_addr == `PMW_OFS_MODE;
  wire sel_ctrl = reg_addr == `PMW_OFS_CTRL;
  wire sel_stat = reg_addr == `PMW_OFS_STAT;
  wire sel_wake = reg_addr == `PMW_OFS_WAKE;
  wire wr_mode  = reg_we & sel_mode;
  wire wr_ctrl  = reg_we & sel_ctrl;
  wire wr_wake  = reg_we & sel_wake;

  wire [7:0] mode_val = {clock_divider_select_r, 1'b0, slow_rdy_r,
                         fast_rdy_r, idle_on_halt_enable_r,
                         fast_clock_select_r};
  wire [7:0] ctrl_val = {sysclk_in_idle_enable_r, 7'h00};
  wire [7:0] stat_val = {6'h00, to_r, pdf_r};
  wire [7:0] rd_val   = sel_mode ? mode_val :
                        sel_ctrl ? ctrl_val :
                        sel_stat ? stat_val :
                        sel_wake ? porta_wake_enable_r : 8'h00;

  // clock source selection
  wire want_sub = ~fast_clock_select_r &
                  (clock_divider_select_r <= `PMW_DIV_SUB_MAX);
  wire want_fast = ~want_sub;
  // fast oscillator only when in use or being restarted
  wire fast_on = ((st_run | st_wake) & (~using_sub_r | want_fast)) |
                 (st_idl1 & ~using_sub_r);
  wire sub_on  = ~st_deep;
  wire osc_ok  = using_sub_r ? slow_rdy_r : fast_rdy_r;

  // divider tick: low (8-code) prescaler bits all ones
  wire [2:0] div_bits = 3'(4'd8 - {1'b0, clock_divider_select_r});
  wire [6:0] div_one  = 7'd1 << div_bits;
  wire [5:0] div_mask = 6'(div_one - 7'd1);
  wire div_tick = &(presc_r | ~div_mask);
  wire sub_edge = sc_s2_r & ~sc_s3_r;
  wire fast_tick = fast_clock_select_r ? 1'b1 : div_tick;
  wire src_tick = using_sub_r ? sub_edge : (fast_on & fast_tick);

  // gate outputs
  wire sys_en = st_run | st_idl1;
  // cpu frozen in all low states, so memory and ports hold
  assign clk_gate.cpu      = st_run;
  assign clk_gate.sys      = sys_en;
  assign clk_gate.wdt      = sub_on & wdt_enable;
  assign clk_gate.tbc      = st_run | st_idl0 | st_idl1;
  assign clk_gate.sub      = sub_on;
  assign clk_gate.fast_osc = fast_on;
  assign clk_gate.div16    = fast_on & fast_rdy_r;
  assign clk_gate.div64    = fast_on & fast_rdy_r;

  // halt destination
  wire wd_or_lvd = wdt_enable | voltage_detect_enable;
  pmw_state_t halt_dest;
  assign halt_dest = idle_on_halt_enable_r ?
                     (sysclk_in_idle_enable_r ? PMW_IDL1 : PMW_IDL0) :
                     (wd_or_lvd ? PMW_SLSUB : PMW_DEEP);
  wire halt_take = st_run & halt_exec;

  // wake sources
  wire  [7:0] pa_fall;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pa
      assign pa_fall[gi] = pa_s3_r[gi] & ~pa_s2_r[gi] &
                           porta_wake_enable_r[gi];
    end
  endgenerate
  wire [7:0] irq_new = irq_req & ~irq_snap_r;
  wire wk_wdt   = st_low & ~st_deep & wdt_overflow;
  wire wk_irq   = st_low & |irq_new;
  wire wk_pa    = st_low & |pa_fall;
  wire wake_any = wk_wdt | wk_irq | wk_pa;
  // interrupt taken only when enabled and stack has a level free
  wire irq_take = |(irq_new & irq_enable) & ~stack_full;
  wire leave_wake = st_wake & osc_ok;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PMW_RUN: begin
        if (halt_exec) begin
          state_nxt = halt_dest;
        end
      end
      PMW_DEEP, PMW_SLSUB, PMW_IDL0, PMW_IDL1: begin
        if (wake_any) begin
          state_nxt = PMW_WAKE;
        end
      end
      PMW_WAKE: begin
        if (osc_ok) begin
          state_nxt = PMW_RUN;
        end
      end
      default: begin
        state_nxt = PMW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= PMW_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // synchronisers for pins and the sub oscillator
  always_ff @(posedge clk) begin
    if (reset) begin
      pa_s1_r <= 8'hff;
      pa_s2_r <= 8'hff;
      pa_s3_r <= 8'hff;
      sc_s1_r <= 1'b0;
      sc_s2_r <= 1'b0;
      sc_s3_r <= 1'b0;
    end else begin
      pa_s1_r <= porta_pins;
      pa_s2_r <= pa_s1_r;
      pa_s3_r <= pa_s2_r;
      sc_s1_r <= slow_osc_clk;
      sc_s2_r <= sc_s1_r;
      sc_s3_r <= sc_s2_r;
    end
  end

  // software registers
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_divider_select_r  <= 3'(`PMW_MODE_RST >> `PMW_MODE_DIV);
      idle_on_halt_enable_r   <= 1'(`PMW_MODE_RST >> `PMW_MODE_IDLE);
      fast_clock_select_r     <= 1'(`PMW_MODE_RST >> `PMW_MODE_FAST);
      sysclk_in_idle_enable_r <= 1'(`PMW_CTRL_RST >> `PMW_CTRL_SYSON);
      porta_wake_enable_r     <= `PMW_WAKE_RST;
    end else begin
      if (wr_mode) begin
        clock_divider_select_r <= reg_wdata[`PMW_MODE_DIV +: 3];
        idle_on_halt_enable_r  <= reg_wdata[`PMW_MODE_IDLE];
        fast_clock_select_r    <= reg_wdata[`PMW_MODE_FAST];
      end
      if (wr_ctrl) begin
        sysclk_in_idle_enable_r <= reg_wdata[`PMW_CTRL_SYSON];
      end
      if (wr_wake) begin
        porta_wake_enable_r <= reg_wdata;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_re ? rd_val : 8'h00;
    end
  end

  // source switch; only moves when the target oscillator is stable
  always_ff @(posedge clk) begin
    if (reset) begin
      using_sub_r <= 1'b0;
    end else if (st_run & want_sub & slow_rdy_r) begin
      using_sub_r <= 1'b1;
    end else if (st_run & want_fast & fast_rdy_r) begin
      using_sub_r <= 1'b0;
    end
  end

  // slow oscillator settle counter
  wire [10:0] slow_tgt = ext_slow_crystal_sel ? `PMW_LXT_CYC : `PMW_INT_SLOW_OSC_CYC;
  wire [10:0] slow_inc = slow_cnt_r + 11'd1;
  always_ff @(posedge clk) begin
    if (reset | ~sub_on) begin
      slow_cnt_r <= 11'd0;
      slow_rdy_r <= 1'b0;
    end else if (~slow_rdy_r) begin
      slow_cnt_r <= slow_inc;
      slow_rdy_r <= slow_inc == slow_tgt;
    end
  end

  // fast oscillator settle counter and prescaler
  wire [4:0] fast_inc = fast_cnt_r + 5'd1;
  always_ff @(posedge clk) begin
    if (reset | ~fast_on) begin
      fast_cnt_r <= 5'd0;
      fast_rdy_r <= 1'b0;
      presc_r    <= 6'h00;
    end else begin
      presc_r <= presc_r + 6'h01;
      if (~fast_rdy_r) begin
        fast_cnt_r <= fast_inc;
        fast_rdy_r <= fast_inc == `PMW_HTO_CYC;
      end
    end
  end

  // status flags; a set beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pdf_r <= 1'b0;
      to_r  <= 1'b0;
    end else begin
      if (halt_take) begin
        pdf_r <= 1'b1;
      end else if (clr_wdt_exec) begin
        pdf_r <= 1'b0;
      end
      if (wk_wdt) begin
        to_r <= 1'b1;
      end else if (halt_take) begin
        to_r <= 1'b0;
      end
    end
  end

  // wake bookkeeping and resume pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_snap_r <= 8'h00;
      wake_src_r <= '0;
      resume_r   <= 1'b0;
      irq_svc_r  <= 1'b0;
      pcsp_r     <= 1'b0;
      wdt_clr_r  <= 1'b0;
      tick_r     <= 1'b0;
    end else begin
      if (halt_take) begin
        irq_snap_r <= irq_req;
      end
      if (wake_any) begin
        wake_src_r <= '{wdt: wk_wdt, irq: wk_irq, porta: wk_pa};
      end
      // watchdog wins, then interrupt, then port A
      pcsp_r    <= leave_wake & wake_src_r.wdt;
      irq_svc_r <= leave_wake & ~wake_src_r.wdt & wake_src_r.irq &
                   irq_take;
      resume_r  <= leave_wake & ~wake_src_r.wdt &
                   (wake_src_r.irq ? ~irq_take : wake_src_r.porta);
      wdt_clr_r <= halt_take | clr_wdt_exec;
      tick_r    <= sys_en & src_tick;
    end
  end

  assign reg_rdata             = rdata_r;
  assign sys_tick              = tick_r;
  assign using_sub_clk         = using_sub_r;
  assign power_state           = state_r;
  assign wdt_clear             = wdt_clr_r;
  // deep sleep keeps the counter frozen after the clear
  assign wdt_run               = wdt_enable & ~st_deep;
  assign power_down_flag       = pdf_r;
  assign watchdog_timeout_flag = to_r;
  assign wake_source           = wake_src_r;
  assign resume_next           = resume_r;
  assign irq_service           = irq_svc_r;
  assign pc_sp_reset           = pcsp_r;

endmodule
`default_nettype wire

//--- verif/pmw_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_ctrl_properties
  import pmw_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       halt_exec,
  input wire logic       wdt_enable,
  input wire logic       voltage_detect_enable,
  input wire logic       wdt_overflow,
  input wire pmw_gate_t  clk_gate,
  input wire logic       using_sub_clk,
  input wire pmw_state_t power_state,
  input wire logic       wdt_clear,
  input wire logic       wdt_run,
  input wire logic       power_down_flag,
  input wire logic       watchdog_timeout_flag,
  input wire pmw_wake_t  wake_source,
  input wire logic       resume_next,
  input wire logic       irq_service,
  input wire logic       pc_sp_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire run_halt = power_state == PMW_RUN && halt_exec;
  wire wdt_low  = power_state inside {PMW_SLSUB, PMW_IDL0, PMW_IDL1};

  a_halt_flags: assert property (run_halt |=> power_down_flag && !watchdog_timeout_flag
    && wdt_clear && power_state != PMW_RUN) else $error("halt entry flags wrong");
  a_lvd_no_deep: assert property (run_halt && (wdt_enable || voltage_detect_enable)
    |=> power_state != PMW_DEEP) else $error("deep sleep with wdt or lvd on");
  a_deep_gates: assert property (power_state == PMW_DEEP
    |-> !(clk_gate.sys || clk_gate.wdt || clk_gate.tbc || wdt_run)) else $error("deep gates");
  a_sleep_with_subclock_state_gates: assert property (power_state == PMW_SLSUB
    |-> !clk_gate.sys && !clk_gate.tbc && clk_gate.sub) else $error("sleep_with_subclock_state gates");
  a_idle_sysclk_off_state_gates: assert property (power_state == PMW_IDL0
    |-> !clk_gate.sys && clk_gate.tbc && clk_gate.sub) else $error("idle_sysclk_off_state gates");
  a_idle_sysclk_on_state_gates: assert property (power_state == PMW_IDL1
    |-> clk_gate.sys && clk_gate.tbc && clk_gate.sub) else $error("idle_sysclk_on_state gates");
  a_cpu_held: assert property (power_state != PMW_RUN |-> !clk_gate.cpu)
    else $error("cpu clock outside run");
  a_sub_fast_off: assert property ($rose(using_sub_clk)
    |-> !(clk_gate.fast_osc || clk_gate.div16 || clk_gate.div64)) else $error("fast on");
  a_wdt_wake: assert property (wdt_low && wdt_overflow
    |=> watchdog_timeout_flag && power_state == PMW_WAKE) else $error("wdt wake");
  a_resume_pulse: assert property ((power_state == PMW_WAKE ##1 power_state == PMW_RUN)
    |-> ##[0:1] (resume_next || irq_service || pc_sp_reset)) else $error("no resume");
  a_pcsp_source: assert property (pc_sp_reset |-> wake_source.wdt)
    else $error("pc reset without wdt wake");
  a_wdt_keeps: assert property (wdt_low && wdt_enable |-> wdt_run)
    else $error("watchdog stopped in sleep_with_subclock_state or idle");
endmodule
bind pmw_ctrl pmw_ctrl_properties i_props (.*);
`default_nettype wire

//--- verif/pmw_far.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_far (
  input  wire logic [7:0] pin_low,
  output logic      [7:0] porta_pins,
  output logic            slow_osc_clk
);
  // pins have pull-ups, so a released pin reads high
  assign porta_pins = ~pin_low;
  // sub oscillator free-running, phase unrelated to clk
  initial begin
    slow_osc_clk = 1'b0;
    forever #733 slow_osc_clk = ~slow_osc_clk;
  end
endmodule
`default_nettype wire

//--- verif/tb_power_mode_wakeup_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmw_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_power_mode_wakeup_control
  import pmw_pkg::*;
;
  logic       clk, reset, reg_we, reg_re, halt_exec, clr_wdt_exec, stack_full;
  logic       wdt_enable, voltage_detect_enable, wdt_overflow, ext_slow_crystal_sel;
  logic [7:0] reg_addr, reg_wdata, irq_req, irq_enable, pin_low, d;
  wire logic [7:0] reg_rdata, porta_pins;
  wire logic  slow_osc_clk, sys_tick, using_sub_clk, wdt_clear, wdt_run, pc_sp_reset;
  wire logic  power_down_flag, watchdog_timeout_flag, resume_next, irq_service;
  pmw_gate_t  clk_gate;
  pmw_state_t power_state;
  pmw_wake_t  wake_source;
  int         fails, comparisons;
  logic [7:0] seen [3];
  logic [7:0] nt;
  pmw_state_t exp_st [5] = '{PMW_DEEP, PMW_SLSUB, PMW_SLSUB, PMW_IDL0, PMW_IDL1};
  logic [3:0] cfg [5] = '{4'h0, 4'h2, 4'h1, 4'h8, 4'hc};

  pmw_ctrl i_dut (.*);
  pmw_far  i_far (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) begin
    seen[0] += resume_next;
    seen[1] += irq_service;
    seen[2] += pc_sp_reset;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  task automatic halt();
    seen = '{8'h00, 8'h00, 8'h00};
    @(posedge clk) halt_exec <= 1'b1;
    @(posedge clk) halt_exec <= 1'b0;
    @(negedge clk);
  endtask
  task automatic until_run();
    for (int n = 0; n < 3000 && power_state !== PMW_RUN; n++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask

  initial begin
    #2000000;
    fails++;
    conclude();
  end

  initial begin
    {reg_we, reg_re, halt_exec, clr_wdt_exec, stack_full, wdt_enable} = '0;
    {voltage_detect_enable, wdt_overflow, ext_slow_crystal_sel} = '0;
    {reg_addr, reg_wdata, irq_req, irq_enable, pin_low} = '0;
    reset = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (30) @(posedge clk);
    rd(`PMW_OFS_MODE, d);
    `CHK(d, 8'h0f)
    rd(`PMW_OFS_STAT, d);
    `CHK(d, 8'h00)
    wr(`PMW_OFS_STAT, 8'hff);
    wr(8'h10, 8'hff);
    rd(8'h10, d);
    `CHK(d, 8'h00)
    rd(`PMW_OFS_STAT, d);
    `CHK(d, 8'h00)
    wr(`PMW_OFS_WAKE, 8'h01);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      wr(`PMW_OFS_MODE, {6'h00, cfg[i][3], 1'b1});
      wr(`PMW_OFS_CTRL, {cfg[i][2], 7'h00});
      wdt_enable <= cfg[i][1];
      voltage_detect_enable <= cfg[i][0];
      halt();
      `CHK(power_state, exp_st[i])
      `CHK({power_down_flag, watchdog_timeout_flag}, 2'b10)
      @(posedge clk) pin_low <= 8'h02;
      repeat (10) @(negedge clk);
      `CHK(power_state, exp_st[i])
      @(posedge clk) pin_low <= 8'h03;
      until_run();
      `CHK(wake_source, 3'b001)
      `CHK(seen[0], 1)
      pin_low <= 8'h00;
      @(posedge clk) clr_wdt_exec <= 1'b1;
      @(posedge clk) clr_wdt_exec <= 1'b0;
      @(negedge clk);
      `CHK(power_down_flag, 1'b0)
    end
    {wdt_enable, voltage_detect_enable} <= 2'b00;
    $display("test halt modes done");
    wr(`PMW_OFS_MODE, 8'h03);
    wr(`PMW_OFS_CTRL, 8'h00);
    for (int i = 0; i < 3; i++) begin
      irq_req <= 8'h01;
      irq_enable <= (i == 1) ? 8'h01 : 8'h03;
      stack_full <= (i == 2);
      halt();
      repeat (10) @(negedge clk);
      `CHK(power_state, PMW_IDL0)
      irq_req <= 8'h03;
      until_run();
      `CHK(wake_source, 3'b010)
      `CHK(seen[1], (i == 0))
      `CHK(seen[0], (i != 0))
    end
    {irq_req, stack_full} <= '0;
    wdt_enable <= 1'b1;
    halt();
    @(posedge clk) wdt_overflow <= 1'b1;
    @(posedge clk) wdt_overflow <= 1'b0;
    until_run();
    `CHK({watchdog_timeout_flag, power_down_flag}, 2'b11)
    `CHK(seen[2], 1)
    `CHK(wake_source, 3'b100)
    $display("test wake sources done");
    for (int i = 0; i < 9; i++) begin
      wr(`PMW_OFS_MODE, (i < 8) ? {i[2:0], 5'h02} : 8'h03);
      for (int n = 0; n < 3000 && using_sub_clk !== (i < 2); n++) @(negedge clk);
      `CHK(using_sub_clk, (i < 2))
      rd(`PMW_OFS_MODE, d);
      `CHK(d[(i < 2) ? `PMW_MODE_SRDY : `PMW_MODE_FRDY], 1'b1)
      // for fast codes the window is a whole number of divider periods, so the count is exact; the sub clock count is 4 or 5
      nt = 8'h00;
      repeat (128) @(negedge clk) nt += sys_tick;
      if (i >= 2) `CHK(nt, (i < 8) ? (2 << (i - 2)) : 128)
      else `CHK(nt inside {[8'd4:8'd5]}, 1'b1)
    end
    $display("test clock select done");
    ext_slow_crystal_sel <= 1'b1;
    wdt_enable <= 1'b0;
    wr(`PMW_OFS_MODE, 8'h01);
    halt();
    `CHK(power_state, PMW_DEEP)
    @(posedge clk) pin_low <= 8'h01;
    until_run();
    `CHK(wake_source, 3'b001)
    rd(`PMW_OFS_MODE, d);
    `CHK(d[`PMW_MODE_SRDY], 1'b0)
    repeat (1024) @(negedge clk);
    rd(`PMW_OFS_MODE, d);
    `CHK(d[`PMW_MODE_SRDY], 1'b1)
    rd(`PMW_OFS_WAKE, d);
    `CHK(d, 8'h01)
    pin_low <= 8'h00;
    $display("test slow crystal done");
    conclude();
  end
endmodule
`default_nettype wire
